// [core/acph_defines.svh]
// Purpose: Constants of the ATA configuration and power command handler
// Assumes: 8-bit task-file registers on a 4-bit register address
// Notes: Offsets 8 and 9 are extra read-only views of the handler state
`ifndef ACPH_DEFINES_SVH
`define ACPH_DEFINES_SVH
`define ACPH_A_DATA 4'h0
`define ACPH_A_FEAT 4'h1
`define ACPH_A_SC 4'h2
`define ACPH_A_SN 4'h3
`define ACPH_A_CL 4'h4
`define ACPH_A_CH 4'h5
`define ACPH_A_CDH 4'h6
`define ACPH_A_CMD 4'h7
`define ACPH_A_CFG 4'h8
`define ACPH_A_MODE 4'h9
`define ACPH_C_SETF 8'hEF
`define ACPH_C_SETM 8'hC6
`define ACPH_C_SLP0 8'h99
`define ACPH_C_SLP1 8'hE6
`define ACPH_C_STB0 8'h96
`define ACPH_C_STB1 8'hE2
`define ACPH_C_STBI0 8'h94
`define ACPH_C_STBI1 8'hE0
`define ACPH_C_XLAT 8'h87
`define ACPH_F_8ON 8'h01
`define ACPH_F_XMODE 8'h03
`define ACPH_F_LADIS 8'h55
`define ACPH_F_NOP0 8'h69
`define ACPH_F_8OFF 8'h81
`define ACPH_F_NOP1 8'h96
`define ACPH_F_NOP2 8'h97
`define ACPH_F_CUR 8'h9A
`define ACPH_T_PIODEF 5'h00
`define ACPH_T_PIOFC 5'h01
`define ACPH_T_DMA 5'h04
`define ACPH_M_DEF 3'h0
`define ACPH_M_NORDY 3'h1
`define ACPH_S_BSY 7
`define ACPH_S_DRDY 6
`define ACPH_S_DRQ 3
`define ACPH_S_ERR 0
`define ACPH_E_ABRT 2
`define ACPH_B_CYLH 9'h000
`define ACPH_B_CYLL 9'h001
`define ACPH_B_HEAD 9'h002
`define ACPH_B_SECT 9'h003
`define ACPH_B_LBA2 9'h004
`define ACPH_B_LBA1 9'h005
`define ACPH_B_LBA0 9'h006
`define ACPH_B_ERASED 9'h013
`define ACPH_B_HOT2 9'h018
`define ACPH_B_HOT1 9'h019
`define ACPH_B_HOT0 9'h01A
`define ACPH_B_LAST 9'h1FF
`define ACPH_V_ERASED 8'hFF
`define ACPH_V_NOTERASED 8'h00
`define ACPH_IDLE_MS 5
`define ACPH_NS_PER_MS 1000000
`define ACPH_CLK_NS 4
`endif

// [core/acph_handler.sv]
// Purpose: Task-file command handler for feature setup, block count and power
// Assumes: Register port and media inputs are on clk_i
// Notes: Data register returns the sector information buffer
// Behaviour
// - Command EFh applies the feature in feature register, parameter in count.
// - Feature 01h moves data on low byte only, 16-bit indicator stays off.
// - Feature 81h returns data register transfers to 16 bits.
// - Feature 03h count byte: upper five bits type, lower three bits mode.
// - Type decode: default PIO, no-ready PIO, flow-control PIO, multi-word DMA.
// - One PIO and one DMA mode held; a new selection replaces the old.
// - Feature 9Ah count is quarter of current limit; pick fastest fitting setting.
// - After 9Ah, lowest accepted value in cylinder low, highest in cylinder high.
// - After power-up run at highest performance until a limit is set.
// - Out-of-range current values are accepted and clamped, no error.
// - 55h disables look-ahead; 69h, 96h, 97h accepted with no effect.
// - Command C6h raises busy and takes the count as sectors per block.
// - Supported count is stored and enabled; otherwise abort and disable.
// - Count zero disables multiple transfers; disabled after power-on.
// - Commands 99h and E6h set busy, sleep, clear busy, interrupt.
// - Any new command written while asleep wakes the device and runs.
// - An idle timer of five milliseconds puts the device to sleep.
// - Standby 96h, E2h and immediate 94h, E0h sleep and interrupt at once.
// - Command 87h returns a 512-byte information buffer for the addressed sector.
// - Buffer holds cylinder, head, sector, then logical address MSB first.
// - Buffer holds erased flag at 13h and erase count at 18h-1Ah.
`timescale 1ns/1ps
`default_nettype none
`include "acph_defines.svh"

module acph_handler
    import acph_pkg::*;
#(
    parameter int unsigned IDLE_CYC = `ACPH_IDLE_MS * `ACPH_NS_PER_MS / `ACPH_CLK_NS,
    parameter logic [7:0] CUR_MIN = 8'h05,
    parameter logic [7:0] CUR_MAX = 8'h19,
    parameter logic [7:0] MULT_MAX = 8'h01,
    parameter logic [2:0] PIO_MAX = 3'h7,
    parameter logic [2:0] DMA_MAX = 3'h7
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic sec_erased_i,
    input wire logic [23:0] hot_count_i,
    output logic [15:0] rdata_o,
    output logic irq_o,
    output logic iois16_n_o,
    output logic sleep_o,
    output logic eight_bit_o,
    output logic [2:0] pio_mode_o,
    output logic iordy_dis_o,
    output logic [2:0] dma_mode_o,
    output logic lookahead_dis_o,
    output logic [7:0] pwr_limit_o,
    output logic mult_en_o,
    output logic [7:0] mult_cnt_o
);
    localparam acph_s_t RST = '{
        st: ACPH_IDLE,
        pwr: CUR_MAX,
        iois16_n: 1'b1,
        default: '0
    };

    acph_s_t s_r;
    acph_s_t s_nxt;
    logic ex_setf;
    logic ex_setm;
    logic ex_slp;
    logic ex_stb;

    // One byte of the sector information buffer
    function automatic logic [7:0] buf_byte(input logic [8:0] i, input acph_s_t s);
        logic [7:0] b;
        b = 8'h00;
        if (i == `ACPH_B_CYLH) begin
            b = s.ch;
        end else if (i == `ACPH_B_CYLL) begin
            b = s.cl;
        end else if (i == `ACPH_B_HEAD) begin
            b = {4'h0, s.cdh[3:0]};
        end else if (i == `ACPH_B_SECT) begin
            b = s.sn;
        end else if (i == `ACPH_B_LBA2) begin
            b = s.ch;
        end else if (i == `ACPH_B_LBA1) begin
            b = s.cl;
        end else if (i == `ACPH_B_LBA0) begin
            b = s.sn;
        end else if (i == `ACPH_B_ERASED) begin
            b = s.erased ? `ACPH_V_ERASED : `ACPH_V_NOTERASED;
        end else if (i == `ACPH_B_HOT2) begin
            b = s.hot[23:16];
        end else if (i == `ACPH_B_HOT1) begin
            b = s.hot[15:8];
        end else if (i == `ACPH_B_HOT0) begin
            b = s.hot[7:0];
        end
        return b;
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = '0;
        // Indicator is registered: low in the cycle after the data register is addressed in 16-bit mode, with or without a strobe
        s_nxt.iois16_n = !((addr_i == `ACPH_A_DATA) && !s_r.eight);

        if (wr_i) begin
            if (addr_i == `ACPH_A_FEAT) begin
                s_nxt.feat = wdata_i[7:0];
            end else if (addr_i == `ACPH_A_SC) begin
                s_nxt.sc = wdata_i[7:0];
            end else if (addr_i == `ACPH_A_SN) begin
                s_nxt.sn = wdata_i[7:0];
            end else if (addr_i == `ACPH_A_CL) begin
                s_nxt.cl = wdata_i[7:0];
            end else if (addr_i == `ACPH_A_CH) begin
                s_nxt.ch = wdata_i[7:0];
            end else if (addr_i == `ACPH_A_CDH) begin
                s_nxt.cdh = wdata_i[7:0];
            end else if (addr_i == `ACPH_A_CMD && s_r.st != ACPH_EXEC) begin
                // A new command aborts any buffer read and wakes from sleep
                s_nxt.cmd = wdata_i[7:0];
                s_nxt.st = ACPH_EXEC;
                s_nxt.abrt = 1'b0;
                s_nxt.irq = 1'b0;
                s_nxt.sleep = 1'b0;
            end
        end

        if (rd_i) begin
            if (addr_i == `ACPH_A_DATA) begin
                if (s_r.st == ACPH_XFER) begin
                    if (s_r.eight) begin
                        s_nxt.rdata = {8'h00, buf_byte(s_r.idx, s_r)};
                        s_nxt.idx = s_r.idx + 9'h001;
                    end else begin
                        s_nxt.rdata = {buf_byte(s_r.idx + 9'h001, s_r), buf_byte(s_r.idx, s_r)};
                        s_nxt.idx = s_r.idx + 9'h002;
                    end
                    if ((s_r.idx | {8'h00, !s_r.eight}) == `ACPH_B_LAST) begin
                        s_nxt.st = ACPH_IDLE;
                    end
                end
            end else if (addr_i == `ACPH_A_FEAT) begin
                s_nxt.rdata[`ACPH_E_ABRT] = s_r.abrt;
            end else if (addr_i == `ACPH_A_SC) begin
                s_nxt.rdata = {8'h00, s_r.sc};
            end else if (addr_i == `ACPH_A_SN) begin
                s_nxt.rdata = {8'h00, s_r.sn};
            end else if (addr_i == `ACPH_A_CL) begin
                s_nxt.rdata = {8'h00, s_r.cl};
            end else if (addr_i == `ACPH_A_CH) begin
                s_nxt.rdata = {8'h00, s_r.ch};
            end else if (addr_i == `ACPH_A_CDH) begin
                s_nxt.rdata = {8'h00, s_r.cdh};
            end else if (addr_i == `ACPH_A_CMD) begin
                // Status read acknowledges the host interrupt
                s_nxt.irq = 1'b0;
                s_nxt.rdata[`ACPH_S_BSY] = (s_r.st == ACPH_EXEC);
                s_nxt.rdata[`ACPH_S_DRDY] = 1'b1;
                s_nxt.rdata[`ACPH_S_DRQ] = (s_r.st == ACPH_XFER);
                s_nxt.rdata[`ACPH_S_ERR] = s_r.abrt;
            end else if (addr_i == `ACPH_A_CFG) begin
                s_nxt.rdata = {8'h00, s_r.mult_en, s_r.sleep, s_r.eight, s_r.la_dis,
                               s_r.iordy_dis, s_r.abrt, 2'b00};
            end else if (addr_i == `ACPH_A_MODE) begin
                s_nxt.rdata = {s_r.mult_cnt, 2'b00, s_r.dma, s_r.pio};
            end
        end

        case (s_r.st)
            ACPH_IDLE: begin
                // Any register access restarts the idle period
                if (wr_i || rd_i || s_r.sleep) begin
                    s_nxt.idle = '0;
                end else if (s_r.idle == IDLE_CYC - 1) begin
                    s_nxt.idle = '0;
                    s_nxt.sleep = 1'b1;
                end else begin
                    s_nxt.idle = s_r.idle + 32'h0000_0001;
                end
            end
            ACPH_EXEC: begin
                // Busy lasts one cycle; completion raises the interrupt
                s_nxt.st = ACPH_IDLE;
                s_nxt.irq = 1'b1;
                s_nxt.idle = '0;
                case (s_r.cmd)
                    `ACPH_C_SETF: begin
                        case (s_r.feat)
                            `ACPH_F_8ON: begin
                                s_nxt.eight = 1'b1;
                            end
                            `ACPH_F_8OFF: begin
                                s_nxt.eight = 1'b0;
                            end
                            `ACPH_F_XMODE: begin
                                case (s_r.sc[7:3])
                                    `ACPH_T_PIODEF: begin
                                        if (s_r.sc[2:0] == `ACPH_M_DEF) begin
                                            s_nxt.pio = 3'h0;
                                            s_nxt.iordy_dis = 1'b0;
                                        end else if (s_r.sc[2:0] == `ACPH_M_NORDY) begin
                                            s_nxt.pio = 3'h0;
                                            s_nxt.iordy_dis = 1'b1;
                                        end else begin
                                            s_nxt.abrt = 1'b1;
                                        end
                                    end
                                    `ACPH_T_PIOFC: begin
                                        if (s_r.sc[2:0] <= PIO_MAX) begin
                                            s_nxt.pio = s_r.sc[2:0];
                                            s_nxt.iordy_dis = 1'b0;
                                        end else begin
                                            s_nxt.abrt = 1'b1;
                                        end
                                    end
                                    `ACPH_T_DMA: begin
                                        if (s_r.sc[2:0] <= DMA_MAX) begin
                                            s_nxt.dma = s_r.sc[2:0];
                                        end else begin
                                            s_nxt.abrt = 1'b1;
                                        end
                                    end
                                    default: begin
                                        s_nxt.abrt = 1'b1;
                                    end
                                endcase
                            end
                            `ACPH_F_LADIS: begin
                                s_nxt.la_dis = 1'b1;
                            end
                            `ACPH_F_NOP0, `ACPH_F_NOP1, `ACPH_F_NOP2: begin
                                s_nxt.abrt = 1'b0;
                            end
                            `ACPH_F_CUR: begin
                                // Highest setting that fits the limit, clamped
                                if (s_r.sc < CUR_MIN) begin
                                    s_nxt.pwr = CUR_MIN;
                                end else if (s_r.sc > CUR_MAX) begin
                                    s_nxt.pwr = CUR_MAX;
                                end else begin
                                    s_nxt.pwr = s_r.sc;
                                end
                                s_nxt.cl = CUR_MIN;
                                s_nxt.ch = CUR_MAX;
                            end
                            default: begin
                                s_nxt.abrt = 1'b1;
                            end
                        endcase
                    end
                    `ACPH_C_SETM: begin
                        if (s_r.sc == 8'h00) begin
                            s_nxt.mult_en = 1'b0;
                            s_nxt.mult_cnt = 8'h00;
                        end else if (s_r.sc <= MULT_MAX) begin
                            s_nxt.mult_en = 1'b1;
                            s_nxt.mult_cnt = s_r.sc;
                        end else begin
                            s_nxt.mult_en = 1'b0;
                            s_nxt.mult_cnt = 8'h00;
                            s_nxt.abrt = 1'b1;
                        end
                    end
                    `ACPH_C_SLP0, `ACPH_C_SLP1: begin
                        s_nxt.sleep = 1'b1;
                    end
                    `ACPH_C_STB0, `ACPH_C_STB1, `ACPH_C_STBI0, `ACPH_C_STBI1: begin
                        s_nxt.sleep = 1'b1;
                    end
                    `ACPH_C_XLAT: begin
                        s_nxt.st = ACPH_XFER;
                        s_nxt.idx = 9'h000;
                        s_nxt.erased = sec_erased_i;
                        s_nxt.hot = hot_count_i;
                    end
                    default: begin
                        s_nxt.abrt = 1'b1;
                    end
                endcase
            end
            ACPH_XFER: begin
                s_nxt.idle = '0;
            end
            default: begin
                s_nxt.st = ACPH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o = s_r.rdata;
    assign irq_o = s_r.irq;
    assign iois16_n_o = s_r.iois16_n;
    assign sleep_o = s_r.sleep;
    assign eight_bit_o = s_r.eight;
    assign pio_mode_o = s_r.pio;
    assign iordy_dis_o = s_r.iordy_dis;
    assign dma_mode_o = s_r.dma;
    assign lookahead_dis_o = s_r.la_dis;
    assign pwr_limit_o = s_r.pwr;
    assign mult_en_o = s_r.mult_en;
    assign mult_cnt_o = s_r.mult_cnt;

    assign ex_setf = (s_r.st == ACPH_EXEC) && (s_r.cmd == `ACPH_C_SETF);
    assign ex_setm = (s_r.st == ACPH_EXEC) && (s_r.cmd == `ACPH_C_SETM);
    assign ex_slp = (s_r.st == ACPH_EXEC)
                    && (s_r.cmd == `ACPH_C_SLP0 || s_r.cmd == `ACPH_C_SLP1);
    assign ex_stb = (s_r.st == ACPH_EXEC)
                    && (s_r.cmd == `ACPH_C_STB0 || s_r.cmd == `ACPH_C_STB1
                        || s_r.cmd == `ACPH_C_STBI0 || s_r.cmd == `ACPH_C_STBI1);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    busy_raise_a: assert property (
        wr_i && addr_i == `ACPH_A_CMD && s_r.st != ACPH_EXEC
        |=> s_r.st == ACPH_EXEC && !irq_o ##1 s_r.st != ACPH_EXEC)
        else $error("command did not hold busy for one cycle");
    eight_on_a: assert property (
        ex_setf && s_r.feat == `ACPH_F_8ON |=> eight_bit_o ##1 iois16_n_o)
        else $error("8-bit mode did not suppress 16-bit indicator");
    eight_off_a: assert property (
        ex_setf && s_r.feat == `ACPH_F_8OFF && !wr_i && !rd_i ##1 addr_i == `ACPH_A_DATA
        |=> !eight_bit_o && !iois16_n_o)
        else $error("16-bit transfers not restored");
    xfer_mode_a: assert property (
        ex_setf && s_r.feat == `ACPH_F_XMODE && s_r.sc[7:3] == `ACPH_T_DMA
        && s_r.sc[2:0] <= DMA_MAX
        |=> dma_mode_o == $past(s_r.sc[2:0]) && $stable(pio_mode_o))
        else $error("DMA mode selection wrong");
    cur_clamp_a: assert property (
        ex_setf && s_r.feat == `ACPH_F_CUR
        |=> pwr_limit_o >= CUR_MIN && pwr_limit_o <= CUR_MAX && !s_r.abrt
            && s_r.cl == CUR_MIN && s_r.ch == CUR_MAX)
        else $error("current limit not clamped or range not reported");
    mult_set_a: assert property (
        ex_setm && s_r.sc > MULT_MAX |=> !mult_en_o && s_r.abrt && irq_o)
        else $error("unsupported block count not rejected");
    mult_zero_a: assert property (
        ex_setm && s_r.sc == 8'h00 |=> !mult_en_o && !s_r.abrt)
        else $error("zero block count did not disable");
    sleep_cmd_a: assert property (
        ex_slp || ex_stb |=> sleep_o && irq_o && s_r.st == ACPH_IDLE)
        else $error("sleep or standby did not sleep and interrupt");
    wake_a: assert property (
        sleep_o && wr_i && addr_i == `ACPH_A_CMD |=> !sleep_o && s_r.st == ACPH_EXEC)
        else $error("command did not wake the device");
    idle_sleep_a: assert property (
        s_r.st == ACPH_IDLE && !sleep_o && !wr_i && !rd_i && s_r.idle == IDLE_CYC - 1
        |=> sleep_o)
        else $error("idle timer did not enter sleep");
    xlat_start_a: assert property (
        s_r.st == ACPH_EXEC && s_r.cmd == `ACPH_C_XLAT
        |=> s_r.st == ACPH_XFER && s_r.idx == 9'h000 && irq_o)
        else $error("translate did not open the buffer");
    reserved_zero_a: assert property (
        s_r.st == ACPH_XFER && s_r.eight && rd_i && addr_i == `ACPH_A_DATA
        && s_r.idx > `ACPH_B_HOT0 |=> rdata_o == 16'h0000)
        else $error("reserved buffer byte not zero");
endmodule
`default_nettype wire

// [core/acph_pkg.sv]
// Purpose: Types of the ATA configuration and power command handler
// Assumes: Nothing beyond the defines header
// Notes: The whole handler state is one packed struct
package acph_pkg;
    typedef enum logic [2:0] {
        ACPH_IDLE = 3'b001,
        ACPH_EXEC = 3'b010,
        ACPH_XFER = 3'b100
    } acph_st_t;

    typedef struct packed {
        acph_st_t st;
        logic [7:0] cmd;
        logic [7:0] feat;
        logic [7:0] sc;
        logic [7:0] sn;
        logic [7:0] cl;
        logic [7:0] ch;
        logic [7:0] cdh;
        logic abrt;
        logic irq;
        logic sleep;
        logic eight;
        logic la_dis;
        logic iordy_dis;
        logic [2:0] pio;
        logic [2:0] dma;
        logic [7:0] pwr;
        logic mult_en;
        logic [7:0] mult_cnt;
        logic [31:0] idle;
        logic [8:0] idx;
        logic erased;
        logic [23:0] hot;
        logic [15:0] rdata;
        logic iois16_n;
    } acph_s_t;
endpackage

// [tb/acph_handler_tb.sv]
// Purpose: Self-checking bench of the command handler
// Assumes: Short idle timer parameter
// Notes: Host model drives the register port
`timescale 1ns/1ps
`default_nettype none
module acph_handler_tb;
    localparam int unsigned IDLE = 20;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic sec_erased_i = 1'b0;
    logic [23:0] hot_count_i = 24'h000000;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, st, q;
    logic wr, rd, irq, ir, i16n, slp, eb, iod, lad, men;
    logic [2:0] pio, dma;
    logic [7:0] pwr, mcnt;
    int errors = 0;
    int n_compared = 0;
    acph_host host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    acph_handler #(.IDLE_CYC(IDLE)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .sec_erased_i(sec_erased_i),
        .hot_count_i(hot_count_i), .rdata_o(rdata), .irq_o(irq), .iois16_n_o(i16n),
        .sleep_o(slp), .eight_bit_o(eb), .pio_mode_o(pio), .iordy_dis_o(iod),
        .dma_mode_o(dma), .lookahead_dis_o(lad), .pwr_limit_o(pwr), .mult_en_o(men),
        .mult_cnt_o(mcnt));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        host.wr(4'h7, c);
        @(posedge clk_i);
        #1 ir = irq;
        host.rd(4'h7, st);
    endtask
    task automatic setf(input logic [7:0] f, input logic [7:0] s);
        host.wr(4'h1, f);
        host.wr(4'h2, s);
        cmd(8'hEF);
    endtask
    task automatic t_eight;
        setf(8'h01, 8'h00);
        host.rd(4'h0, q);
        chk({eb, i16n}, 16'h0003);
        // Data read straight after completion shows the indicator return at once
        host.wr(4'h1, 8'h81);
        host.wr(4'h2, 8'h00);
        host.wr(4'h7, 8'hEF);
        host.rd(4'h0, q);
        chk({eb, i16n}, 16'h0000);
    endtask
    task automatic t_xmode;
        logic [7:0] sc [6] = '{8'h00, 8'h01, 8'h0B, 8'h22, 8'h0C, 8'h10};
        logic [7:0] ex [6] = '{8'h00, 8'h40, 8'h03, 8'h13, 8'h14, 8'h94};
        for (int i = 0; i < 6; i++) begin
            setf(8'h03, sc[i]);
            chk({st[0], iod, dma, pio}, ex[i]);
        end
    endtask
    task automatic t_cur;
        logic [7:0] sc [3] = '{8'h06, 8'h01, 8'hFF};
        logic [7:0] ex [3] = '{8'h06, 8'h05, 8'h19};
        for (int i = 0; i < 3; i++) begin
            setf(8'h9A, sc[i]);
            chk({st[0], pwr}, ex[i]);
            host.rd(4'h4, q);
            chk(q[7:0], 16'h0005);
            host.rd(4'h5, q);
            chk(q[7:0], 16'h0019);
        end
    endtask
    task automatic t_feat;
        logic [7:0] f [4] = '{8'h55, 8'h69, 8'h96, 8'h97};
        for (int i = 0; i < 4; i++) begin
            setf(f[i], 8'h00);
            chk({st[0], lad, eb, pwr}, 16'h0219);
        end
    endtask
    task automatic t_mult;
        logic [7:0] sc [4] = '{8'h01, 8'h02, 8'h01, 8'h00};
        logic [1:0] ex [4] = '{2'b01, 2'b10, 2'b01, 2'b00};
        for (int i = 0; i < 4; i++) begin
            host.wr(4'h2, sc[i]);
            cmd(8'hC6);
            chk({st[0], men}, ex[i]);
            if (i == 0) chk(mcnt, 16'h0001);
            if (i == 0) begin
                host.rd(4'h9, q);
                chk(q, 16'h0114);
            end
            if (i == 1) begin
                host.rd(4'h1, q);
                chk(q, 16'h0004);
            end
        end
    endtask
    task automatic t_sleep;
        logic [7:0] c [6] = '{8'h99, 8'hE6, 8'h96, 8'hE2, 8'h94, 8'hE0};
        for (int i = 0; i < 6; i++) begin
            cmd(c[i]);
            chk({ir, slp, st[0]}, 16'h0006);
            setf(8'h69, 8'h00);
            chk({ir, slp, st[0]}, 16'h0004);
        end
    endtask
    task automatic t_idle;
        int n;
        for (n = 0; n < 3 * IDLE && slp !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        chk(n >= IDLE - 3 && n <= IDLE + 3, 16'h0001);
    endtask
    task automatic t_xlat(input logic e8);
        logic [7:0] b [512];
        logic [15:0] w;
        for (int i = 0; i < 512; i++) b[i] = 8'h00;
        b[0] = 8'h12;
        b[1] = 8'h34;
        b[2] = 8'h07;
        b[3] = 8'h56;
        b[4] = 8'h12;
        b[5] = 8'h34;
        b[6] = 8'h56;
        b[19] = e8 ? 8'h00 : 8'hFF;
        b[24] = e8 ? 8'h00 : 8'hAB;
        b[25] = e8 ? 8'h00 : 8'hCD;
        b[26] = e8 ? 8'h00 : 8'hEF;
        sec_erased_i <= !e8;
        hot_count_i <= e8 ? 24'h000000 : 24'hABCDEF;
        if (e8) setf(8'h01, 8'h00);
        host.wr(4'h5, 8'h12);
        host.wr(4'h4, 8'h34);
        host.wr(4'h3, 8'h56);
        host.wr(4'h6, 8'hA7);
        cmd(8'h87);
        chk(st[3], 16'h0001);
        for (int i = 0; i < 512; i += e8 ? 1 : 2) begin
            host.rd(4'h0, w);
            chk(w, e8 ? {8'h00, b[i]} : {b[i + 1], b[i]});
        end
        host.rd(4'h7, st);
        chk(st[3], 16'h0000);
        if (e8) setf(8'h81, 8'h00);
    endtask
    task automatic end_sim;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        #1 chk({pwr, men, eb}, 16'h0064);
        t_eight();
        // 8-bit mode stays off while transfer modes are chosen
        t_xmode();
        t_cur();
        t_feat();
        t_mult();
        t_sleep();
        t_idle();
        t_xlat(1'b0);
        t_xlat(1'b1);
        end_sim();
    end
endmodule
`default_nettype wire

// [tb/acph_host.sv]
// Purpose: Host register port master
// Assumes: Signals change right after a rising edge
// Notes: Read data taken in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module acph_host (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic [3:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= {8'h00, d};
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 q = rdata_i;
    endtask
endmodule
`default_nettype wire
